// ==== hdl/leie_pkg.sv ====
/*
 * leie_pkg: shared constants of the link error interrupt enable block:
 * register offsets, bit positions of the link error sources, writable
 * masks and reset values.
 * Assumes a 32-bit register port with byte addresses; every register
 * takes one aligned word.
 */
package leie_pkg;

    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 8;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_STATUS      = 8'hC4;
    localparam logic [ADDR_W-1:0] OFF_STATUS_EN   = 8'hC8;
    localparam logic [ADDR_W-1:0] OFF_SIGNAL_EN   = 8'hCC;
    localparam logic [ADDR_W-1:0] OFF_PENDING     = 8'hD0;
    localparam logic [ADDR_W-1:0] OFF_OVERRUN     = 8'hD4;

    // link error source bit positions
    localparam int unsigned BIT_HEADER        = 0;
    localparam int unsigned BIT_RES_PACKET    = 1;
    localparam int unsigned BIT_RETRY_EXPIRED = 2;
    localparam int unsigned BIT_CRC           = 3;
    localparam int unsigned BIT_FRAMING       = 4;
    localparam int unsigned BIT_TRANSACTION_ID = 5;
    localparam int unsigned BIT_UNRECOVERABLE = 7;
    localparam int unsigned BIT_END_BUSY      = 8;
    localparam int unsigned BIT_DESCRIPTOR_DMA = 15;
    localparam int unsigned BIT_CMD_RES_TMO   = 16;
    localparam int unsigned BIT_DEADLOCK_TMO  = 17;
    localparam int unsigned VENDOR_LSB        = 27;
    localparam int unsigned VENDOR_MSB        = 31;

    // implemented bits: 31-27, 17-15, 8-7, 5-0; bits 26-18, 14-9, 6 reserved
    localparam logic [DATA_W-1:0] MASK_IMPL     = 32'hF803_81BF;
    localparam logic [DATA_W-1:0] MASK_VENDOR   = 32'hF800_0000;

    localparam logic [DATA_W-1:0] RST_STATUS    = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_STATUS_EN = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_SIGNAL_EN = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RD_UNMAPPED   = 32'h0000_0000;

    // register identity of a decoded access
    typedef enum logic [2:0] {
        LEIE_REG_NONE,
        LEIE_REG_STATUS,
        LEIE_REG_STATUS_EN,
        LEIE_REG_SIGNAL_EN,
        LEIE_REG_PENDING,
        LEIE_REG_OVERRUN
    } leie_reg_t;

endpackage : leie_pkg

// ==== hdl/leie_sticky.sv ====
/*
 * leie_sticky: vector of sticky error flags. A flag sets on an event
 * pulse when its latch enable is 1, and clears on a clear request.
 * Assumes events and clears are one-cycle pulses on the same clock.
 */
module leie_sticky (
    input  wire logic                        clock,
    input  wire logic                        rst,
    input  wire logic [leie_pkg::DATA_W-1:0] event_pulse,
    input  wire logic [leie_pkg::DATA_W-1:0] latch_en,
    input  wire logic                        clear,
    output logic      [leie_pkg::DATA_W-1:0] flags_nxt,
    output logic      [leie_pkg::DATA_W-1:0] flags
);

    logic [leie_pkg::DATA_W-1:0] set_bits;
    logic [leie_pkg::DATA_W-1:0] kept_bits;

    // reserved positions never latch
    assign set_bits  = event_pulse & latch_en & leie_pkg::MASK_IMPL;
    assign kept_bits = clear ? '0 : flags;
    // a set in the clearing cycle survives the clear
    assign flags_nxt = kept_bits | set_bits;

    always_ff @(posedge clock) begin
        if (rst) begin
            flags <= leie_pkg::RST_STATUS;
        end else begin
            flags <= flags_nxt;
        end
    end

endmodule : leie_sticky

// ==== hdl/leie_top.sv ====
/*
 * leie_top: link error interrupt enable block. Gates detected link
 * errors into a sticky status register and gates the status onto one
 * level interrupt output.
 * Assumes link error detectors give one-cycle pulses on the same clock,
 * and a register master with single-cycle strobes, read data one cycle
 * after the read strobe.
 */
// Added by the designer: the strobed register port.
// Summary of operation
// - framing error latches into status only while status-enable bit 4 is 1
// - CRC error latches into status only while status-enable bit 3 is 1
// - header error latches into status only while status-enable bit 0 is 1
// - retry-expired flag sets only while status-enable bit 2 is 1
// - transaction id bit 5 and response packet bit 1 gate status; read-write
// - 32-bit read-write signal enable register at offset 0xCC, 1 enables; here only implemented bits are writable, bits 26-18, 14-9, 6 read 0
// - signal-enable bits 31 to 27 individually enable vendor error bits
// - deadlock timeout status raises interrupt only when signal-enable bit 17 is 1
// - command response timeout raises interrupt only when signal-enable bit 16 is 1
// - dma error bit 15, end busy bit 8, unrecoverable bit 7; 14-9, 6 reserved
// - every signal-enable bit gates interrupt when its status bit is set
module leie_top (
    input  wire logic                        clock,
    input  wire logic                        rst,
    // register port
    input  wire logic [leie_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [leie_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                        reg_write,
    input  wire logic                        reg_read,
    output logic      [leie_pkg::DATA_W-1:0] reg_rdata,
    // link error detector pulses, one bit per status position
    input  wire logic [leie_pkg::DATA_W-1:0] link_error_pulse,
    // interrupt to the host controller
    output logic                             link_error_irq
);

    // decode of a register address
    function automatic leie_pkg::leie_reg_t decode(
        input logic [leie_pkg::ADDR_W-1:0] addr
    );
        leie_pkg::leie_reg_t sel;
        sel = leie_pkg::LEIE_REG_NONE;
        if (addr == leie_pkg::OFF_STATUS) begin
            sel = leie_pkg::LEIE_REG_STATUS;
        end else if (addr == leie_pkg::OFF_STATUS_EN) begin
            sel = leie_pkg::LEIE_REG_STATUS_EN;
        end else if (addr == leie_pkg::OFF_SIGNAL_EN) begin
            sel = leie_pkg::LEIE_REG_SIGNAL_EN;
        end else if (addr == leie_pkg::OFF_PENDING) begin
            sel = leie_pkg::LEIE_REG_PENDING;
        end else if (addr == leie_pkg::OFF_OVERRUN) begin
            sel = leie_pkg::LEIE_REG_OVERRUN;
        end
        return sel;
    endfunction : decode

    // writable view of a data word: reserved bits forced to zero
    function automatic logic [leie_pkg::DATA_W-1:0] impl_bits(
        input logic [leie_pkg::DATA_W-1:0] value
    );
        return value & leie_pkg::MASK_IMPL;
    endfunction : impl_bits

    leie_pkg::leie_reg_t         wr_sel;
    leie_pkg::leie_reg_t         rd_sel;
    logic                        wr_status_en;
    logic                        wr_signal_en;
    logic                        rd_status;
    logic                        rd_overrun;

    logic [leie_pkg::DATA_W-1:0] status_en_r;
    logic [leie_pkg::DATA_W-1:0] status_en_nxt;
    logic [leie_pkg::DATA_W-1:0] signal_en_r;
    logic [leie_pkg::DATA_W-1:0] signal_en_nxt;
    logic [leie_pkg::DATA_W-1:0] status_q;
    logic [leie_pkg::DATA_W-1:0] status_nxt;
    logic [leie_pkg::DATA_W-1:0] overrun_q;
    logic [leie_pkg::DATA_W-1:0] overrun_nxt;
    logic [leie_pkg::DATA_W-1:0] overrun_ev;
    logic [leie_pkg::DATA_W-1:0] pending;
    logic [leie_pkg::DATA_W-1:0] pending_nxt;
    logic [leie_pkg::DATA_W-1:0] rdata_nxt;
    logic                        irq_nxt;
    logic                        link_error_irq_r;
    logic [leie_pkg::DATA_W-1:0] reg_rdata_r;

    assign wr_sel = reg_write ? decode(reg_addr) : leie_pkg::LEIE_REG_NONE;
    assign rd_sel = reg_read  ? decode(reg_addr) : leie_pkg::LEIE_REG_NONE;

    assign wr_status_en = (wr_sel == leie_pkg::LEIE_REG_STATUS_EN);
    assign wr_signal_en = (wr_sel == leie_pkg::LEIE_REG_SIGNAL_EN);
    assign rd_status    = (rd_sel == leie_pkg::LEIE_REG_STATUS);
    assign rd_overrun   = (rd_sel == leie_pkg::LEIE_REG_OVERRUN);

    // both enable registers are read-write on implemented bits only
    assign status_en_nxt = wr_status_en ? impl_bits(reg_wdata) : status_en_r;
    assign signal_en_nxt = wr_signal_en ? impl_bits(reg_wdata) : signal_en_r;

    always_ff @(posedge clock) begin
        if (rst) begin
            status_en_r <= leie_pkg::RST_STATUS_EN;
            signal_en_r <= leie_pkg::RST_SIGNAL_EN;
        end else begin
            status_en_r <= status_en_nxt;
            signal_en_r <= signal_en_nxt;
        end
    end

    // status: a detected error latches only where its status enable is 1;
    // a read of the status register clears it, but a coincident event wins
    leie_sticky u_status (
        .clock       (clock),
        .rst         (rst),
        .event_pulse (link_error_pulse),
        .latch_en    (status_en_r),
        .clear       (rd_status),
        .flags_nxt   (status_nxt),
        .flags       (status_q)
    );

    // overrun: an enabled error arrived while its status bit was still set
    assign overrun_ev = status_q & ~({leie_pkg::DATA_W{rd_status}});

    leie_sticky u_overrun (
        .clock       (clock),
        .rst         (rst),
        .event_pulse (link_error_pulse & overrun_ev),
        .latch_en    (status_en_r),
        .clear       (rd_overrun),
        .flags_nxt   (overrun_nxt),
        .flags       (overrun_q)
    );

    // per-bit signal gating; vendor, timeout, dma, end busy and
    // unrecoverable bits follow the same per-bit rule
    assign pending     = status_q & signal_en_r;
    assign pending_nxt = status_nxt & signal_en_nxt;

    // registered from next values so the output tracks the registers
    assign irq_nxt = |pending_nxt;

    // read data, reserved bits zero, unmapped addresses zero
    assign rdata_nxt =
        (rd_sel == leie_pkg::LEIE_REG_STATUS)    ? impl_bits(status_q)    :
        (rd_sel == leie_pkg::LEIE_REG_STATUS_EN) ? impl_bits(status_en_r) :
        (rd_sel == leie_pkg::LEIE_REG_SIGNAL_EN) ? impl_bits(signal_en_r) :
        (rd_sel == leie_pkg::LEIE_REG_PENDING)   ? impl_bits(pending)     :
        (rd_sel == leie_pkg::LEIE_REG_OVERRUN)   ? impl_bits(overrun_q)   :
        leie_pkg::RD_UNMAPPED;

    always_ff @(posedge clock) begin
        if (rst) begin
            reg_rdata_r      <= leie_pkg::RD_UNMAPPED;
            link_error_irq_r <= 1'b0;
        end else begin
            reg_rdata_r      <= rdata_nxt;
            link_error_irq_r <= irq_nxt;
        end
    end

    assign reg_rdata      = reg_rdata_r;
    assign link_error_irq = link_error_irq_r;

endmodule : leie_top

// ==== tb/leie_top_sva.sv ====
/* leie_top_sva: port-level assertions for leie_top.
   Assumes it is bound to leie_top; one clock, synchronous reset. */
module leie_top_sva (
    input wire logic                        clock,
    input wire logic                        rst,
    input wire logic [leie_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [leie_pkg::DATA_W-1:0] reg_wdata,
    input wire logic                        reg_write,
    input wire logic                        reg_read,
    input wire logic [leie_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [leie_pkg::DATA_W-1:0] link_error_pulse,
    input wire logic                        link_error_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic rd_stat = reg_read && reg_addr == leie_pkg::OFF_STATUS;
    wire logic rd_pend = reg_read && reg_addr == leie_pkg::OFF_PENDING;
    wire logic rd_sig  = reg_read && reg_addr == leie_pkg::OFF_SIGNAL_EN;
    wire logic wr_sig  = reg_write && reg_addr == leie_pkg::OFF_SIGNAL_EN;
    wire logic any_evt = |link_error_pulse;
    wire logic mapped  = reg_addr inside {leie_pkg::OFF_STATUS, leie_pkg::OFF_STATUS_EN,
        leie_pkg::OFF_SIGNAL_EN, leie_pkg::OFF_PENDING, leie_pkg::OFF_OVERRUN};
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    sequence s_sig_wr_rd;
        wr_sig ##1 rd_sig;
    endsequence
    sequence s_clear_twice;
        rd_stat && !any_evt ##1 rd_stat;
    endsequence
    chk_rdata_idle: assert property (!reg_read |=> reg_rdata == '0)
        else $error("read data not zero outside a read");
    chk_rsvd_zero: assert property (reg_read |=>
        (reg_rdata & ~leie_pkg::MASK_IMPL) == '0)
        else $error("reserved bits read nonzero");
    chk_pend_irq: assert property (rd_pend |=>
        (reg_rdata != '0) == $past(link_error_irq))
        else $error("interrupt disagrees with pending bits");
    chk_irq_cause: assert property ($rose(link_error_irq) |->
        $past(any_evt) || $past(wr_sig))
        else $error("interrupt rose without cause");
    chk_irq_drop: assert property ($fell(link_error_irq) |->
        $past(rd_stat) || $past(wr_sig))
        else $error("interrupt fell without cause");
    chk_unmapped_zero: assert property (reg_read && !mapped |=> reg_rdata == '0)
        else $error("unmapped read nonzero");
    chk_sig_back: assert property (s_sig_wr_rd |=>
        reg_rdata == ($past(reg_wdata, 2) & leie_pkg::MASK_IMPL))
        else $error("signal enable readback wrong");
    chk_read_clears: assert property (s_clear_twice |=> reg_rdata == '0)
        else $error("status not cleared by read");
endmodule : leie_top_sva

bind leie_top leie_top_sva u_sva (.clock, .rst, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .link_error_pulse, .link_error_irq);

// ==== tb/tb_top.sv ====
/* tb_top: register-level bench for leie_top.
   Assumes leie_pkg and the checker are compiled first. */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0;
    logic        rst   = 1'b1;
    logic [7:0]  reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic [31:0] reg_rdata;
    logic [31:0] link_error_pulse = '0;
    logic        link_error_irq;
    logic [31:0] m;
    logic [31:0] pend_exp = '0;
    logic        pend = 1'b0;
    int          miscompares = 0;
    int          n_checks = 0;
    always #2 clock = ~clock;
    leie_top DUT (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .link_error_pulse(link_error_pulse), .link_error_irq(link_error_irq));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
            miscompares++;
        end
    endtask : chk
    // one bus cycle; read data of the previous cycle is checked here
    task automatic acc(input logic w, input logic r, input logic [7:0] a,
                       input logic [31:0] d, input logic [31:0] e, input logic [31:0] p);
        @(posedge clock);
        reg_write <= w;
        reg_read <= r;
        reg_addr <= a;
        reg_wdata <= d;
        link_error_pulse <= p;
        #1;
        if (pend) chk(reg_rdata, pend_exp);
        pend = r;
        pend_exp = e;
    endtask : acc
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, 1'b0, a, d, '0, '0);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, 1'b1, a, '0, e, '0);
    endtask : rd
    task automatic pulse(input logic [31:0] p);
        acc(1'b0, 1'b0, '0, '0, '0, p);
    endtask : pulse
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results
    initial begin
        #20000;
        miscompares++;
        results();
    end
    initial begin
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        rd(leie_pkg::OFF_STATUS, '0);
        rd(leie_pkg::OFF_STATUS_EN, leie_pkg::RST_STATUS_EN);
        rd(leie_pkg::OFF_SIGNAL_EN, leie_pkg::RST_SIGNAL_EN);
        rd(leie_pkg::OFF_PENDING, '0);
        wr(leie_pkg::OFF_SIGNAL_EN, 32'hFFFF_FFFF);
        rd(leie_pkg::OFF_SIGNAL_EN, leie_pkg::MASK_IMPL);
        wr(leie_pkg::OFF_STATUS_EN, 32'hFFFF_FFFF);
        rd(leie_pkg::OFF_STATUS_EN, leie_pkg::MASK_IMPL);
        wr(8'hC0, 32'hFFFF_FFFF);
        rd(8'hC0, '0);
        wr(leie_pkg::OFF_STATUS, 32'hFFFF_FFFF);
        rd(leie_pkg::OFF_STATUS, '0);
        for (int b = 0; b < 32; b++) begin
            m = 32'h1 << b;
            if ((m & leie_pkg::MASK_IMPL) != '0) begin
                // only bit b may latch; its interrupt is masked
                wr(leie_pkg::OFF_STATUS_EN, m);
                wr(leie_pkg::OFF_SIGNAL_EN, leie_pkg::MASK_IMPL & ~m);
                pulse(32'hFFFF_FFFF);
                pulse('0);
                chk({31'h0, link_error_irq}, 32'h0);
                rd(leie_pkg::OFF_STATUS, m);
                rd(leie_pkg::OFF_STATUS, '0);
                // all bits may latch; only bit b is pulsed and reaches the interrupt
                wr(leie_pkg::OFF_SIGNAL_EN, m);
                wr(leie_pkg::OFF_STATUS_EN, leie_pkg::MASK_IMPL);
                pulse(m);
                pulse('0);
                chk({31'h0, link_error_irq}, 32'h1);
                rd(leie_pkg::OFF_PENDING, m);
                rd(leie_pkg::OFF_STATUS, m);
                pulse('0);
                chk({31'h0, link_error_irq}, 32'h0);
            end
        end
        pulse('0);
        // vendor bit: overrun on a repeated event, set wins over a read clear
        m = 32'h1 << leie_pkg::VENDOR_MSB;
        wr(leie_pkg::OFF_SIGNAL_EN, m);
        pulse(m);
        pulse(m);
        pulse('0);
        chk({31'h0, link_error_irq}, 32'h1);
        rd(leie_pkg::OFF_OVERRUN, m);
        rd(leie_pkg::OFF_OVERRUN, '0);
        acc(1'b0, 1'b1, leie_pkg::OFF_STATUS, '0, m, m);
        rd(leie_pkg::OFF_STATUS, m);
        pulse(m);
        pulse('0);
        // reset in mid-run with the interrupt high
        @(posedge clock);
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        rd(leie_pkg::OFF_STATUS, leie_pkg::RST_STATUS);
        rd(leie_pkg::OFF_STATUS_EN, leie_pkg::RST_STATUS_EN);
        rd(leie_pkg::OFF_SIGNAL_EN, leie_pkg::RST_SIGNAL_EN);
        rd(leie_pkg::OFF_OVERRUN, '0);
        pulse(m);
        pulse('0);
        chk({31'h0, link_error_irq}, 32'h0);
        rd(leie_pkg::OFF_STATUS, '0);
        pulse('0);
        results();
    end
endmodule : tb_top
